// *** src/scad_pkg.sv ***
// Purpose: shared constants and types for the command/address decoder
// Assumes: one clock, inputs synchronous to clk
// Notes: command codes are {cs_n, ras_n, cas_n, we_n}
package scad_pkg;
	// ------------------------------------------------------------
	// widths
	// ------------------------------------------------------------
	localparam int ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam int COL_W = 10;
	localparam int NUM_BANKS = 8;
	localparam int DATA_W = 8;
	localparam int NUM_MR = 4;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int AP_BIT = 10;
	localparam int BC_BIT = 12;
	localparam int TERM_STROBE_EN_BIT = 11;
	localparam int MREG_ONE_TERM_B0 = 2;
	localparam int MREG_ONE_TERM_B1 = 6;
	localparam int MREG_ONE_TERM_B2 = 9;
	localparam int MREG_TWO_WR_TERM_LO = 9;
	localparam int MREG_TWO_WR_TERM_HI = 10;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [13:0] MR_RST = 14'h0000;
	// ------------------------------------------------------------
	// mode register selectors and commands
	// ------------------------------------------------------------
	localparam logic [2:0] MR_SEL_ONE = 3'h1;
	localparam logic [2:0] MR_SEL_TWO = 3'h2;
	typedef enum logic [3:0] {
		SCAD_CMD_MODE_SET = 4'h0,
		SCAD_CMD_REF = 4'h1,
		SCAD_CMD_PRE = 4'h2,
		SCAD_CMD_ACT = 4'h3,
		SCAD_CMD_WR = 4'h4,
		SCAD_CMD_ZQ = 4'h6,
		SCAD_CMD_RD = 4'h5,
		SCAD_CMD_NOP = 4'h7
	} scad_cmd_t;
endpackage

// *** src/scad_odt_ctl.sv ***
// Purpose: termination enable gating and per-pin termination outputs
// Assumes: mode register fields supplied from the decoder
// Notes: purely combinational control plus a registered enable
`timescale 1ns/10ps
`default_nettype none
module scad_term_ctl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// controls
	input wire logic die_termination_enable,
	input wire logic self_refresh,
	input wire logic [13:0] mode_reg_one,
	input wire logic [13:0] mode_reg_two,
	// termination enables per pin group
	output logic term_dq,
	output logic term_strobe,
	output logic term_mask_pin,
	output logic term_complement
);
	typedef struct packed {
		logic on;
	} scad_term_st_t;
	scad_term_st_t st_r, st_nxt;
	logic term_allowed;

	// ------------------------------------------------------------
	// gating
	// ------------------------------------------------------------
	// both nominal and dynamic fields zero means termination is off
	always_comb begin
		term_allowed = mode_reg_one[scad_pkg::MREG_ONE_TERM_B0]
			| mode_reg_one[scad_pkg::MREG_ONE_TERM_B1]
			| mode_reg_one[scad_pkg::MREG_ONE_TERM_B2]
			| (|mode_reg_two[scad_pkg::MREG_TWO_WR_TERM_HI:scad_pkg::MREG_TWO_WR_TERM_LO]);
		st_nxt = st_r;
		st_nxt.on = die_termination_enable & term_allowed & ~self_refresh;
	end

	// registered so the enable changes only on a clock edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs: complement pin only when the strobe function is on
	assign term_dq = st_r.on;
	assign term_strobe = st_r.on;
	assign term_mask_pin = st_r.on;
	assign term_complement = st_r.on & mode_reg_one[scad_pkg::TERM_STROBE_EN_BIT];
endmodule
`default_nettype wire

// *** src/scad_mask.sv ***
// Purpose: write data mask capture on both strobe edges
// Assumes: strobe edges arrive as one-cycle pulses synchronous to clk
// Notes: masked beats never reach the array write port
`timescale 1ns/10ps
`default_nettype none
module scad_mask (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// beat inputs
	input wire logic write_active,
	input wire logic strobe_rise,
	input wire logic strobe_fall,
	input wire logic mask_or_term_strobe,
	input wire logic strobe_mode_sel,
	input wire logic [7:0] beat_data,
	// beat outputs
	output logic beat_write,
	output logic [7:0] beat_wdata,
	output logic beat_masked
);
	typedef struct packed {
		logic wr;
		logic [7:0] data;
		logic masked;
	} scad_mask_st_t;
	scad_mask_st_t st_r, st_nxt;
	logic beat;
	logic write_data_mask;

	// ------------------------------------------------------------
	// beat capture
	// ------------------------------------------------------------
	// in strobe mode the shared pin carries no mask, so no beat is dropped
	always_comb begin
		beat = write_active & (strobe_rise | strobe_fall);
		write_data_mask = mask_or_term_strobe & ~strobe_mode_sel;
		st_nxt = st_r;
		st_nxt.wr = beat & ~write_data_mask;
		st_nxt.masked = beat & write_data_mask;
		if (beat) begin
			st_nxt.data = beat_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign beat_write = st_r.wr;
	assign beat_wdata = st_r.data;
	assign beat_masked = st_r.masked;
endmodule
`default_nettype wire

// *** src/scad_decode.sv ***
// Purpose: command, address and control decoding of a DRAM input stage
// Assumes: inputs synchronous to clk; reset_n asynchronous active low
// Notes: sys_rst and reset_n both clear all state
`timescale 1ns/10ps
`default_nettype none
module scad_decode (
	// clock and resets
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reset_n,
	// command and address pins
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_enable_n,
	input wire logic [2:0] bank_select,
	input wire logic [13:0] address_inputs,
	input wire logic die_termination_enable,
	input wire logic self_refresh,
	// write data path
	input wire logic write_active,
	input wire logic strobe_rise,
	input wire logic strobe_fall,
	input wire logic mask_or_term_strobe,
	input wire logic [7:0] beat_data,
	// decoded command
	output logic cmd_valid,
	output logic [3:0] cmd_code,
	output logic [2:0] cmd_bank,
	output logic [13:0] row_addr,
	output logic [9:0] col_addr,
	output logic auto_precharge,
	output logic burst_chop,
	output logic [7:0] precharge_banks,
	output logic [7:0] open_banks,
	// mode registers
	output logic [13:0] mode_reg_one,
	output logic [13:0] mode_reg_two,
	output logic mode_reg_written,
	// termination and strobe pin mode
	output logic term_dq,
	output logic term_strobe,
	output logic term_mask_pin,
	output logic term_complement,
	output logic term_strobe_mode,
	// write beats
	output logic beat_write,
	output logic [7:0] beat_wdata,
	output logic beat_masked
);
	typedef struct packed {
		logic valid;
		logic [3:0] code;
		logic [2:0] bank;
		logic [13:0] row;
		logic [9:0] col;
		logic ap;
		logic bc;
		logic [7:0] pre;
		logic [7:0] open;
		logic [13:0] mreg0;
		logic [13:0] mreg1;
		logic [13:0] mreg2;
		logic [13:0] mreg3;
		logic mr_wr;
	} scad_dec_st_t;
	scad_dec_st_t st_r, st_nxt;
	logic rst;
	logic [3:0] pins;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// one-hot bank mask, used for precharge and activate bookkeeping
	function automatic logic [7:0] bank_onehot(input logic [2:0] b);
		bank_onehot = 8'h01 << b;
	endfunction

	// either reset clears all state; array contents are not kept
	assign rst = sys_rst | ~reset_n;
	assign pins = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	// pulses last one cycle; chip select high gives no command at all
	always_comb begin
		st_nxt = st_r;
		st_nxt.valid = 1'b0;
		st_nxt.mr_wr = 1'b0;
		st_nxt.pre = 8'h00;
		st_nxt.code = pins;
		if (!chip_select_n) begin
			st_nxt.valid = (pins != scad_pkg::SCAD_CMD_NOP);
			st_nxt.bank = bank_select;
			unique case (pins)
				scad_pkg::SCAD_CMD_ACT: begin
					st_nxt.row = address_inputs;
					st_nxt.open = st_r.open | bank_onehot(bank_select);
				end
				scad_pkg::SCAD_CMD_RD,
				scad_pkg::SCAD_CMD_WR: begin
					st_nxt.col = address_inputs[9:0];
					st_nxt.ap = address_inputs[scad_pkg::AP_BIT];
					st_nxt.bc = ~address_inputs[scad_pkg::BC_BIT];
					if (address_inputs[scad_pkg::AP_BIT]) begin
						st_nxt.pre = bank_onehot(bank_select);
						st_nxt.open = st_r.open & ~bank_onehot(bank_select);
					end
				end
				scad_pkg::SCAD_CMD_PRE: begin
					if (address_inputs[scad_pkg::AP_BIT]) begin
						st_nxt.pre = 8'hff;
						st_nxt.open = 8'h00;
					end else begin
						st_nxt.pre = bank_onehot(bank_select);
						st_nxt.open = st_r.open & ~bank_onehot(bank_select);
					end
				end
				scad_pkg::SCAD_CMD_MODE_SET: begin
					st_nxt.mr_wr = 1'b1;
					// selected register only; upper bank bit is reserved
					unique case (bank_select[1:0])
						2'h0: st_nxt.mreg0 = address_inputs;
						2'h1: st_nxt.mreg1 = address_inputs;
						2'h2: st_nxt.mreg2 = address_inputs;
						2'h3: st_nxt.mreg3 = address_inputs;
					endcase
				end
				default: begin
				end
			endcase
		end
	end

	// every input but the resets sampled on the clock's rising edge only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
			st_r.code <= scad_pkg::SCAD_CMD_NOP;
			st_r.mreg1 <= scad_pkg::MR_RST;
			st_r.mreg2 <= scad_pkg::MR_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cmd_valid = st_r.valid;
	assign cmd_code = st_r.code;
	assign cmd_bank = st_r.bank;
	assign row_addr = st_r.row;
	assign col_addr = st_r.col;
	assign auto_precharge = st_r.ap;
	assign burst_chop = st_r.bc;
	assign precharge_banks = st_r.pre;
	assign open_banks = st_r.open;
	assign mode_reg_one = st_r.mreg1;
	assign mode_reg_two = st_r.mreg2;
	assign mode_reg_written = st_r.mr_wr;
	assign term_strobe_mode = st_r.mreg1[scad_pkg::TERM_STROBE_EN_BIT];

	// ------------------------------------------------------------
	// termination and mask submodules
	// ------------------------------------------------------------
	scad_term_ctl u_term (
		.clk(clk),
		.rst(rst),
		.die_termination_enable(die_termination_enable),
		.self_refresh(self_refresh),
		.mode_reg_one(st_r.mreg1),
		.mode_reg_two(st_r.mreg2),
		.term_dq(term_dq),
		.term_strobe(term_strobe),
		.term_mask_pin(term_mask_pin),
		.term_complement(term_complement)
	);

	scad_mask u_mask (
		.clk(clk),
		.rst(rst),
		.write_active(write_active),
		.strobe_rise(strobe_rise),
		.strobe_fall(strobe_fall),
		.mask_or_term_strobe(mask_or_term_strobe),
		.strobe_mode_sel(st_r.mreg1[scad_pkg::TERM_STROBE_EN_BIT]),
		.beat_data(beat_data),
		.beat_write(beat_write),
		.beat_wdata(beat_wdata),
		.beat_masked(beat_masked)
	);
endmodule
`default_nettype wire

// *** testbench/scad_ctrl_model.sv ***
// Purpose: controller model on the command pins
// Assumes: shares clk with the decoder
// Notes: deselect and inverted bus between commands
`timescale 1ns/10ps
`default_nettype none
module scad_ctrl_model (
	// clock
	input wire logic clk,
	// command pins
	output logic chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
	output logic [2:0] bank_select,
	output logic [13:0] address_inputs
);
	// one command for one sampling edge, then release
	task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		@(posedge clk);
		{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} <= c;
		{bank_select, address_inputs} <= {b, a};
		@(posedge clk);
		{chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} <= 4'hf;
		{bank_select, address_inputs} <= ~{b, a}; // stale bus never looks valid
	endtask
	// deselected from time zero
	initial {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hf;
	initial {bank_select, address_inputs} = 17'h0;
endmodule
`default_nettype wire

// *** testbench/scad_decode_sva.sv ***
// Purpose: port checks of the decoder
// Assumes: one clock domain
// Notes: bound to every decoder instance
`timescale 1ns/10ps
`default_nettype none
module scad_decode_sva (
	// clock, resets, pins
	input wire logic clk, sys_rst, reset_n,
	input wire logic chip_select_n, row_strobe_n, col_strobe_n, write_enable_n,
	input wire logic [2:0] bank_select, cmd_bank,
	input wire logic [13:0] address_inputs, row_addr, mode_reg_one, mode_reg_two,
	input wire logic die_termination_enable, self_refresh, write_active,
	input wire logic strobe_rise, strobe_fall, mask_or_term_strobe,
	// results
	input wire logic [7:0] beat_data, beat_wdata, precharge_banks, open_banks,
	input wire logic cmd_valid, auto_precharge, burst_chop, mode_reg_written,
	input wire logic [9:0] col_addr,
	input wire logic term_dq, term_strobe, term_mask_pin, term_complement,
	input wire logic beat_write, beat_masked
);
	// helpers; rtt means termination allowed by the mode registers
	wire logic [3:0] cmd = {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
	wire logic ap_in = address_inputs[10];
	wire logic bc_in = address_inputs[12];
	wire logic rtt = |{mode_reg_one[9], mode_reg_one[6], mode_reg_one[2], mode_reg_two[10:9]};
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst || !reset_n);
	property p_desel; cmd_valid |-> $past(cmd) < 4'h7; endproperty
	a_desel: assert property (p_desel) else $error("bad accept");
	property p_act; cmd == 4'h3 |=> cmd_valid && row_addr == $past(address_inputs)
		&& open_banks[$past(bank_select)]; endproperty
	a_act: assert property (p_act) else $error("bad activate");
	property p_rw; cmd inside {4'h4, 4'h5} |=> col_addr == 10'($past(address_inputs))
		&& cmd_bank == $past(bank_select) && auto_precharge == $past(ap_in)
		&& burst_chop == !$past(bc_in); endproperty
	a_rw: assert property (p_rw) else $error("bad access");
	property p_pall; cmd == 4'h2 && ap_in |=> precharge_banks == 8'hff && open_banks == 8'h0;
	endproperty
	a_pall: assert property (p_pall) else $error("bad precharge all");
	property p_pone; cmd == 4'h2 && !ap_in |=> precharge_banks == 8'h1 << $past(bank_select);
	endproperty
	a_pone: assert property (p_pone) else $error("bad precharge");
	property p_mrs; cmd == 4'h0 && bank_select == 3'h1 |=>
		mode_reg_one == $past(address_inputs) && mode_reg_written; endproperty
	a_mrs: assert property (p_mrs) else $error("bad mode set");
	property p_ton; die_termination_enable && !self_refresh && rtt && cmd != 4'h0 |=>
		term_dq && term_strobe && term_mask_pin; endproperty
	a_ton: assert property (p_ton) else $error("no termination");
	property p_toff; self_refresh || !rtt |=> !term_dq; endproperty
	a_toff: assert property (p_toff) else $error("termination on");
	property p_tcomp; term_complement == (term_dq && mode_reg_one[11]); endproperty
	a_tcomp: assert property (p_tcomp) else $error("bad complement");
	property p_mask; write_active && (strobe_rise || strobe_fall) && mask_or_term_strobe
		&& !mode_reg_one[11] |=> beat_masked && !beat_write; endproperty
	a_mask: assert property (p_mask) else $error("beat not masked");
	property p_beat; write_active && strobe_fall && !mask_or_term_strobe |=>
		beat_write && beat_wdata == $past(beat_data); endproperty
	a_beat: assert property (p_beat) else $error("beat lost");
	property p_rst; disable iff (sys_rst) !reset_n |-> open_banks == 8'h0 && !cmd_valid;
	endproperty
	a_rst: assert property (p_rst) else $error("reset pin ignored");
endmodule
bind scad_decode scad_decode_sva i_scad_decode_sva (.*);
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench of the decoder
// Assumes: results settle 1 ns after the sampling edge
// Notes: bank 2 state after auto-precharge is left unchecked
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	// ---
	// signals and instances
	// ---
	logic clk, sys_rst, reset_n, die_termination_enable, self_refresh, write_active;
	logic strobe_rise, strobe_fall, mask_or_term_strobe, chip_select_n, row_strobe_n;
	logic col_strobe_n, write_enable_n, cmd_valid, auto_precharge, burst_chop, beat_masked;
	logic mode_reg_written, term_dq, term_strobe, term_mask_pin, term_complement;
	logic term_strobe_mode, beat_write;
	logic [2:0] bank_select, cmd_bank;
	logic [3:0] cmd_code;
	logic [7:0] beat_data, beat_wdata, precharge_banks, open_banks;
	logic [9:0] col_addr;
	logic [13:0] address_inputs, row_addr, mode_reg_one, mode_reg_two;
	int err_total, tests_run;
	scad_decode i_scad_decode (.*);
	scad_ctrl_model i_scad_ctrl_model (.*);
	always #12.5 clk = ~clk;
	// ---
	// tasks
	// ---
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %h vs %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
		i_scad_ctrl_model.issue(c, b, a);
		#1;
	endtask
	task automatic tick();
		repeat (2) @(posedge clk);
		#1;
	endtask
	// one beat on a strobe edge, then mask and data flipped
	task automatic beat(input logic r, input logic m, input logic [7:0] d, input logic wr);
		@(posedge clk);
		{write_active, strobe_rise, strobe_fall} <= {1'b1, r, !r};
		{mask_or_term_strobe, beat_data} <= {m, d};
		@(posedge clk);
		{write_active, strobe_rise, strobe_fall} <= 3'h0;
		{mask_or_term_strobe, beat_data} <= {!m, ~d};
		#1;
		chk({beat_write, beat_masked, wr ? beat_wdata : d}, {wr, !wr, d});
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// watchdog at about eighteen times the expected run
	initial begin
		#40000;
		err_total++;
		conclude();
	end
	// ---
	// tests
	// ---
	initial begin
		{clk, sys_rst, reset_n, die_termination_enable, self_refresh} = 5'h0c;
		{write_active, strobe_rise, strobe_fall, mask_or_term_strobe, beat_data} = 12'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		cmd(4'h0, 3'h1, 14'h0004);
		chk({mode_reg_one, mode_reg_written}, {14'h0004, 1'b1});
		cmd(4'h0, 3'h2, 14'h0600);
		chk({mode_reg_two, mode_reg_one}, {14'h0600, 14'h0004});
		for (int c = 0; c < 16; c++) begin
			cmd(c[3:0], 3'h3, 14'h0);
			chk({cmd_valid, cmd_code}, {c < 7, c[3:0]});
		end
		cmd(4'h3, 3'h2, 14'h3abc);
		chk({row_addr, open_banks}, {14'h3abc, 8'h0c});
		cmd(4'h5, 3'h2, 14'h0432);
		chk({col_addr, auto_precharge, burst_chop, precharge_banks},
			{10'h32, 2'h3, 8'h4});
		cmd(4'h4, 3'h5, 14'h1155);
		chk({cmd_bank, col_addr, auto_precharge, burst_chop}, {3'h5, 10'h155, 2'h0});
		cmd(4'h3, 3'h1, 14'h0);
		cmd(4'h2, 3'h1, 14'h0);
		chk({precharge_banks, open_banks & 8'h0a}, 16'h0208);
		cmd(4'h2, 3'h6, 14'h0400);
		chk({precharge_banks, open_banks}, 16'hff00);
		@(posedge clk) die_termination_enable <= 1'b1;
		tick();
		chk({term_dq, term_strobe, term_mask_pin, term_complement}, 4'he);
		beat(1'b1, 1'b1, 8'h5a, 1'b0);
		beat(1'b0, 1'b0, 8'ha5, 1'b1);
		@(posedge clk) self_refresh <= 1'b1;
		tick();
		chk(term_dq, 1'b0);
		@(posedge clk) self_refresh <= 1'b0;
		cmd(4'h0, 3'h1, 14'h0804);
		tick();
		chk({term_complement, term_strobe_mode}, 2'h3);
		beat(1'b0, 1'b1, 8'h3c, 1'b1);
		cmd(4'h0, 3'h1, 14'h0);
		cmd(4'h0, 3'h2, 14'h0);
		tick();
		chk(term_dq, 1'b0);
		// reset pin dropped after an edge must clear state before the next one
		cmd(4'h3, 3'h4, 14'h1);
		@(posedge clk) reset_n <= 1'b0;
		#1;
		chk(open_banks, 8'h0);
		@(posedge clk) reset_n <= 1'b1;
		tick();
		conclude();
	end
endmodule
`default_nettype wire
